// *** serial_regs_pkg.sv ***
// Constants and carrier types for the serial status and test register block.
// Assumes a 16-bit register map behind a one-bit-wide serial slave port.
package serial_regs_pkg;

  localparam logic [5:0] ADDR_SOFT_RESET  = 6'h00;
  localparam logic [5:0] ADDR_PACKET_RAM  = 6'h01;
  localparam logic [5:0] ADDR_VERSION     = 6'h2C;
  localparam logic [5:0] ADDR_RX_STATUS   = 6'h2D;
  localparam logic [5:0] ADDR_STAMP_HIGH  = 6'h2E;
  localparam logic [5:0] ADDR_STAMP_LOW   = 6'h2F;
  localparam logic [5:0] ADDR_CONT_TEST   = 6'h30;
  localparam logic [5:0] ADDR_MOD_TEST    = 6'h31;

  localparam int CONT_TEST_BIT = 15;
  localparam int HDR_READ_BIT  = 7;
  localparam logic [4:0] HDR_LAST_BIT  = 5'h07;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0F;

  localparam logic [2:0] MOD_NORMAL     = 3'h0;
  localparam logic [2:0] MOD_CARRIER    = 3'h1;
  localparam logic       CONT_TEST_RST  = 1'h0;
  localparam logic [7:0] CCA_RST        = 8'h00;
  localparam logic [6:0] FRAME_LEN_RST  = 7'h00;
  localparam logic [23:0] STAMP_RST     = 24'h000000;

  typedef struct packed {
    logic [7:0]  cca_avg;
    logic [6:0]  frame_length_field;
    logic        sfd_det;
    logic        payload_start;
    logic [23:0] event_counter;
    logic        stream_mode;
  } radio_in_t;

  typedef struct packed {
    logic       continuous_test;
    logic [2:0] modulator_test_sel;
  } test_ctl_t;

  typedef struct packed {
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_d;
    logic        ce_s1;
    logic        ce_s2;
    logic        mosi_s1;
    logic        mosi_s2;
    logic [4:0]  bitcnt;
    logic        in_hdr;
    logic        is_rd;
    logic [5:0]  addr;
    logic [15:0] rx;
    logic [15:0] tx;
    logic        miso;
    logic        miso_oe_n;
    logic        cont;
    logic [2:0]  mod_sel;
    logic [7:0]  cca;
    logic [6:0]  flen;
    logic [23:0] stamp;
    logic        sirq;
    logic        soft_rst;
    logic        ram_wr;
    logic        ram_rd;
    logic [15:0] ram_wdata;
  } state_t;

endpackage

// *** serial_status_regs.sv ***
// Serial slave port with the status and test register group.
// Assumes the host drives chip enable, serial clock and data asynchronously
// to mclk, and the radio inputs come from logic on mclk.
// Summary of operation
// - Version register at 2C, 9-bit code.
// - Status high byte reports averaged channel assessment.
// - Frame length latched into status on delimiter.
// - Stream length load raises interrupt; a read whose header addresses status clears it.
// - 24-bit timestamp split high byte, low word.
// - Timestamp captured at payload start.
// - Bit 15 set makes operations continuous.
// - Modulator field: 000 normal, 001 carrier.
// - Register access needs mclk running; serial pins are sampled on mclk.
// - Single transaction: header then two data bytes.
// - Header gives direction and address; data follows.
// - Bursts continue with further words after header.
// - Registers 16 bits, 64 addresses decoded.
// - Packet RAM reached at a register address.
// - Write to address 00 resets test controls, frame length and interrupt.
// - Header bit 7 read; bits 5:0 address.
// - Fewer than 24 edges write no register.
// - Sample on rising edge, drive on falling.
// - Bytes travel most significant bit first.
`timescale 1ns/100ps
`default_nettype none

module serial_status_regs #(
  parameter logic [8:0] VERSION_CODE = 9'h0A5 // Arbitrary value.
) (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       ce_n,
  input  wire logic                       serial_clock,
  input  wire logic                       mosi,
  output logic                            miso,
  output logic                            miso_oe_n,
  input  wire serial_regs_pkg::radio_in_t radio,
  input  wire logic [15:0]                ram_rdata,
  output logic                            ram_rd,
  output logic                            ram_wr,
  output logic [15:0]                     ram_wdata,
  output serial_regs_pkg::test_ctl_t      test_ctl,
  output logic                            stream_irq,
  output logic                            soft_reset
);

  serial_regs_pkg::state_t q_ff;
  serial_regs_pkg::state_t nxt_q;
  logic                    active;
  logic                    rise;
  logic                    fall;
  logic                    hdr_done;
  logic                    word_done;
  logic [15:0]             in_word;
  logic                    sirq_set;

  // Read decode; unmapped addresses and reserved bits return zero.
  function automatic logic [15:0] rd_word(
    input logic [5:0]              a,
    input serial_regs_pkg::state_t s,
    input logic [15:0]             ram
  );
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      serial_regs_pkg::ADDR_PACKET_RAM: w = ram;
      serial_regs_pkg::ADDR_VERSION:    w = {7'h00, VERSION_CODE};
      serial_regs_pkg::ADDR_RX_STATUS:
        w = {s.cca, 1'b0, s.flen};
      serial_regs_pkg::ADDR_STAMP_HIGH: w = {8'h00, s.stamp[23:16]};
      serial_regs_pkg::ADDR_STAMP_LOW:  w = s.stamp[15:0];
      serial_regs_pkg::ADDR_CONT_TEST:  w = {s.cont, 15'h0000};
      serial_regs_pkg::ADDR_MOD_TEST:   w = {13'h0000, s.mod_sel};
      default:                          w = 16'h0000;
    endcase
    return w;
  endfunction

  // Pins are sampled on mclk, so the port moves only on serial clock edges
  // and needs mclk running to reach the registers.
  assign active    = ~q_ff.ce_s2;
  assign rise      = active & q_ff.sck_s2 & ~q_ff.sck_d;
  assign fall      = active & ~q_ff.sck_s2 & q_ff.sck_d;
  assign in_word   = {q_ff.rx[14:0], q_ff.mosi_s2};
  assign hdr_done  = rise & q_ff.in_hdr
                     & (q_ff.bitcnt == serial_regs_pkg::HDR_LAST_BIT);
  assign word_done = rise & ~q_ff.in_hdr
                     & (q_ff.bitcnt == serial_regs_pkg::WORD_LAST_BIT);
  assign sirq_set  = radio.sfd_det & radio.stream_mode;

  always_comb begin
    nxt_q          = q_ff;
    nxt_q.sck_s1   = serial_clock;
    nxt_q.sck_s2   = q_ff.sck_s1;
    nxt_q.sck_d    = q_ff.sck_s2;
    nxt_q.ce_s1    = ce_n;
    nxt_q.ce_s2    = q_ff.ce_s1;
    nxt_q.mosi_s1  = mosi;
    nxt_q.mosi_s2  = q_ff.mosi_s1;
    nxt_q.soft_rst = 1'b0;
    nxt_q.ram_wr   = 1'b0;
    nxt_q.ram_rd   = 1'b0;
    nxt_q.cca      = radio.cca_avg;
    if (radio.sfd_det) begin
      nxt_q.flen = radio.frame_length_field;
    end
    if (radio.payload_start) begin
      nxt_q.stamp = radio.event_counter;
    end

    if (!active) begin
      nxt_q.bitcnt    = 5'h00;
      nxt_q.in_hdr    = 1'b1;
      nxt_q.miso      = 1'b0;
      nxt_q.miso_oe_n = 1'b1;
    end else if (rise) begin
      nxt_q.rx     = in_word;
      nxt_q.bitcnt = q_ff.bitcnt + 5'h01;
      if (hdr_done) begin
        // Header: top bit is direction, low six bits the address.
        nxt_q.in_hdr = 1'b0;
        nxt_q.bitcnt = 5'h00;
        nxt_q.is_rd  = in_word[serial_regs_pkg::HDR_READ_BIT];
        nxt_q.addr   = in_word[5:0];
        if (in_word[serial_regs_pkg::HDR_READ_BIT]) begin
          nxt_q.tx        = rd_word(in_word[5:0], q_ff, ram_rdata);
          nxt_q.miso_oe_n = 1'b0;
          nxt_q.ram_rd    = in_word[5:0] == serial_regs_pkg::ADDR_PACKET_RAM;
          if (in_word[5:0] == serial_regs_pkg::ADDR_RX_STATUS) begin
            nxt_q.sirq = 1'b0;
          end
        end
      end else if (word_done) begin
        // Writes land only on a whole word, i.e. at the 24th edge or later.
        nxt_q.bitcnt = 5'h00;
        if (q_ff.addr != serial_regs_pkg::ADDR_PACKET_RAM) begin
          nxt_q.addr = q_ff.addr + 6'h01;
        end
        if (q_ff.is_rd) begin
          nxt_q.tx     = rd_word(nxt_q.addr, q_ff, ram_rdata);
          nxt_q.ram_rd = nxt_q.addr == serial_regs_pkg::ADDR_PACKET_RAM;
        end else begin
          unique case (q_ff.addr)
            serial_regs_pkg::ADDR_SOFT_RESET: begin
              nxt_q.soft_rst = 1'b1;
              nxt_q.cont     = serial_regs_pkg::CONT_TEST_RST;
              nxt_q.mod_sel  = serial_regs_pkg::MOD_NORMAL;
              nxt_q.flen     = serial_regs_pkg::FRAME_LEN_RST;
              nxt_q.sirq     = 1'b0;
            end
            serial_regs_pkg::ADDR_PACKET_RAM: begin
              nxt_q.ram_wr    = 1'b1;
              nxt_q.ram_wdata = in_word;
            end
            serial_regs_pkg::ADDR_CONT_TEST:
              nxt_q.cont = in_word[serial_regs_pkg::CONT_TEST_BIT];
            serial_regs_pkg::ADDR_MOD_TEST:
              nxt_q.mod_sel = in_word[2:0];
            default: ;
          endcase
        end
      end
    end else if (fall && q_ff.is_rd && !q_ff.in_hdr) begin
      nxt_q.miso = q_ff.tx[15];
      nxt_q.tx   = {q_ff.tx[14:0], 1'b0};
    end

    // A new length event beats a status read in the same cycle.
    if (sirq_set) begin
      nxt_q.sirq = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff           <= '0;
      q_ff.sck_d     <= 1'b0;
      q_ff.ce_s1     <= 1'b1;
      q_ff.ce_s2     <= 1'b1;
      q_ff.in_hdr    <= 1'b1;
      q_ff.miso_oe_n <= 1'b1;
      q_ff.cont      <= serial_regs_pkg::CONT_TEST_RST;
      q_ff.mod_sel   <= serial_regs_pkg::MOD_NORMAL;
      q_ff.cca       <= serial_regs_pkg::CCA_RST;
      q_ff.flen      <= serial_regs_pkg::FRAME_LEN_RST;
      q_ff.stamp     <= serial_regs_pkg::STAMP_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign miso                        = q_ff.miso;
  assign miso_oe_n                   = q_ff.miso_oe_n;
  assign ram_rd                      = q_ff.ram_rd;
  assign ram_wr                      = q_ff.ram_wr;
  assign ram_wdata                   = q_ff.ram_wdata;
  assign test_ctl = '{continuous_test:    q_ff.cont,
                      modulator_test_sel: q_ff.mod_sel};
  assign stream_irq                  = q_ff.sirq;
  assign soft_reset                  = q_ff.soft_rst;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_soft_write;
    word_done && !q_ff.is_rd && q_ff.addr == serial_regs_pkg::ADDR_SOFT_RESET;
  endsequence

  sequence s_soft_pulse;
    soft_reset && !test_ctl.continuous_test ##1 !soft_reset;
  endsequence

  a_version_read: assert property (
    hdr_done && in_word[7] && in_word[5:0] == serial_regs_pkg::ADDR_VERSION
    |=> q_ff.tx == {7'h00, VERSION_CODE})
    else $error("version word not loaded");

  a_cca_track: assert property (
    ##1 q_ff.cca == $past(radio.cca_avg))
    else $error("status energy byte stale");

  a_length_latch: assert property (
    radio.sfd_det && !word_done
    |=> q_ff.flen == $past(radio.frame_length_field))
    else $error("frame length not latched");

  a_stream_set: assert property (
    sirq_set |=> stream_irq)
    else $error("stream interrupt not raised");

  a_stream_clear: assert property (
    hdr_done && in_word[7] && in_word[5:0] == serial_regs_pkg::ADDR_RX_STATUS
    && !sirq_set |=> !stream_irq)
    else $error("status read left interrupt set");

  a_stamp_capture: assert property (
    radio.payload_start |=> q_ff.stamp == $past(radio.event_counter))
    else $error("timestamp not captured");

  a_short_nowrite: assert property (
    !(word_done && !q_ff.is_rd) |=> $stable(test_ctl))
    else $error("register changed without whole word");

  a_miso_rise: assert property (
    rise |=> $stable(miso))
    else $error("output changed on rising edge");

  a_soft_reset: assert property (
    s_soft_write |=> s_soft_pulse)
    else $error("soft reset pulse wrong");

  a_oe_idle: assert property (
    q_ff.ce_s2 |=> miso_oe_n && !miso)
    else $error("output driven while deselected");

endmodule

`default_nettype wire

// *** serial_host_model.sv ***
// Host-side serial master model for the status and test register block.
// Assumes mclk at 100 MHz; the serial clock runs 16 mclk a bit, low at rest.
`timescale 1ns/100ps
`default_nettype none
module serial_host (
  input  wire logic mclk,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output logic      ce_n,
  output logic      serial_clock,
  output logic      mosi
);
  initial begin
    ce_n = 1'b1;
    serial_clock = 1'b0;
    mosi = 1'b0;
  end
  // The header comes first, then data bits up to nrise rises in all; header bit 7 selects read.
  // Mclk runs through every frame, so packet RAM always sees its clock.
  task automatic txn(input logic [7:0] hdr,
                     input logic [47:0] dat,
                     input int nrise, output logic [47:0] rd);
    logic b;
    rd = '0;
    b = 1'b0;
    @(posedge mclk) ce_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < nrise; i++) begin
      b = (i < 8) ? hdr[7 - i] : dat[55 - i];
      mosi <= b;
      repeat (8) @(posedge mclk);
      serial_clock <= 1'b1;
      // A released line reads as the inverse, so it never passes for data.
      if (i >= 8) rd[55 - i] = miso_oe_n ? ~miso : miso;
      repeat (8) @(posedge mclk);
      serial_clock <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    ce_n <= 1'b1;
    mosi <= ~b;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** test_serial_status_regs.sv ***
// Self-checking bench for the serial status and test register block.
// Assumes the host model above and a constant packet RAM word.
`timescale 1ns/100ps
`default_nettype none
module test_serial_status_regs;
  localparam logic [8:0] VC = 9'h123; // Arbitrary value.
  typedef struct packed {
    logic        we;
    logic [5:0]  addr;
    logic [15:0] wd;
    logic [15:0] exp;
    logic [3:0]  ctl;
  } row_t;
  logic mclk, sys_rst, ce_n, serial_clock, mosi, miso, miso_oe_n;
  logic ram_rd, ram_wr, stream_irq, soft_reset;
  logic [15:0] ram_rdata, ram_wdata, q;
  logic [47:0] rd;
  serial_regs_pkg::radio_in_t radio;
  serial_regs_pkg::test_ctl_t test_ctl;
  int fails = 0, num_checks = 0, n_wr = 0, n_rd = 0, n_srst = 0;
  row_t rows [8] = '{
    '{1'b0, 6'h2C, 16'h0000, {7'h00, VC}, 4'h0},
    '{1'b1, 6'h2C, 16'hFFFF, {7'h00, VC}, 4'h0},
    '{1'b1, 6'h30, 16'hFFFF, 16'h8000, 4'h8},
    '{1'b1, 6'h31, 16'hFFFF, 16'h0007, 4'hF},
    '{1'b1, 6'h31, 16'h0001, 16'h0001, 4'h9},
    '{1'b1, 6'h30, 16'h0000, 16'h0000, 4'h1},
    '{1'b1, 6'h31, 16'h0000, 16'h0000, 4'h0},
    '{1'b1, 6'h3F, 16'hFFFF, 16'h0000, 4'h0}};
  serial_status_regs #(.VERSION_CODE(VC)) serial_status_regs_inst (
    .mclk(mclk), .sys_rst(sys_rst), .ce_n(ce_n),
    .serial_clock(serial_clock), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .radio(radio), .ram_rdata(ram_rdata),
    .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
    .test_ctl(test_ctl), .stream_irq(stream_irq), .soft_reset(soft_reset));
  serial_host serial_host_inst (
    .mclk(mclk), .miso(miso), .miso_oe_n(miso_oe_n), .ce_n(ce_n),
    .serial_clock(serial_clock), .mosi(mosi));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (ram_wr === 1'b1) n_wr <= n_wr + 1;
    if (ram_rd === 1'b1) n_rd <= n_rd + 1;
    if (soft_reset === 1'b1) n_srst <= n_srst + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    serial_host_inst.txn({2'b00, a}, {d, 32'h0}, 24, rd);
  endtask
  task automatic rdw(input logic [5:0] a, output logic [15:0] v);
    serial_host_inst.txn({2'b10, a}, 48'hA5A55A5AA5A5, 24, rd);
    v = rd[47:32];
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    final_report;
  end
  initial begin
    sys_rst = 1'b1;
    radio = '0;
    ram_rdata = 16'hC3C3;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check(16'(test_ctl), 16'h0);
    check(16'(stream_irq), 16'h0);
    rdw(serial_regs_pkg::ADDR_RX_STATUS, q);
    check(q, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].addr, rows[i].wd);
      rdw(rows[i].addr, q);
      check(q, rows[i].exp);
      check(16'(test_ctl), 16'(rows[i].ctl));
    end
    $display("test table done");
    radio.cca_avg <= 8'h5A;
    radio.frame_length_field <= 7'h7F;
    radio.event_counter <= 24'h123456;
    radio.stream_mode <= 1'b1;
    radio.sfd_det <= 1'b1;
    radio.payload_start <= 1'b1;
    @(posedge mclk);
    radio.sfd_det <= 1'b0;
    radio.payload_start <= 1'b0;
    radio.frame_length_field <= 7'h11;
    radio.event_counter <= 24'hFFFFFF;
    repeat (2) @(posedge mclk);
    check(16'(stream_irq), 16'h1);
    serial_host_inst.txn(8'hAD, 48'h0, 56, rd);
    check(rd[47:32], 16'h5A7F);
    check(rd[31:16], 16'h0012);
    check(rd[15:0], 16'h3456);
    check(16'(stream_irq), 16'h0);
    $display("test radio done");
    // One rise short of a full word must leave the enable untouched.
    serial_host_inst.txn(8'h30, {16'h8000, 32'h0}, 23, rd);
    check(16'(test_ctl), 16'h0);
    serial_host_inst.txn(8'h30, 48'h800000010000, 40, rd);
    check(16'(test_ctl), 16'h9);
    serial_host_inst.txn(8'h01, 48'h123456780000, 40, rd);
    check(16'(n_wr), 16'h2);
    check(ram_wdata, 16'h5678);
    rdw(serial_regs_pkg::ADDR_PACKET_RAM, q);
    check(q, 16'hC3C3);
    check(16'(n_rd > 0), 16'h1);
    $display("test burst done");
    wr(serial_regs_pkg::ADDR_SOFT_RESET, 16'h0000);
    check(16'(n_srst), 16'h1);
    check(16'(test_ctl), 16'h0);
    rdw(serial_regs_pkg::ADDR_RX_STATUS, q);
    check(q, 16'h5A00);
    $display("test soft reset done");
    final_report;
  end
endmodule
`default_nettype wire
